// >>> core/fmr_pkg.sv
// Shared constants and types for the FSK modem mode and receive retiming ends
package fmr_pkg;
	// ==========================================================
	// Clock and timing
	localparam int CLK_HZ      = 10_000_000;
	localparam int BIT_RATE    = 1200;
	localparam int BIT_CYC     = CLK_HZ / BIT_RATE;
	localparam int HALF_BIT    = BIT_CYC / 2;
	localparam int TONE_2200   = 2200;
	localparam int TONE_1200   = 1200;
	localparam int TONE_487    = 487;
	localparam int TONE_387    = 387;
	localparam int HALF_2200   = CLK_HZ / (2 * TONE_2200);
	localparam int HALF_1200   = CLK_HZ / (2 * TONE_1200);
	localparam int HALF_487    = CLK_HZ / (2 * TONE_487);
	localparam int HALF_387    = CLK_HZ / (2 * TONE_387);
	localparam int TEON_US     = 1000;
	localparam int TEOFF_US    = 500;
	localparam int DET_ON_CYC  = TEON_US * (CLK_HZ / 1_000_000);
	localparam int DET_OFF_CYC = TEOFF_US * (CLK_HZ / 1_000_000);
	localparam int ZP_WAIT_MS  = 20;
	localparam int ZP_WAIT_CYC = ZP_WAIT_MS * (CLK_HZ / 1000);
	localparam int STB_HALF_NS = 800;
	localparam int STB_HALF    = (STB_HALF_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int CNT_W       = 20;
	localparam int CHAR_BITS   = 9;
	localparam int NPHASE      = 2 * CHAR_BITS;
	localparam logic [7:0] DEV_IDLE  = 8'hDC;
	localparam logic [2:0] HOST_IDLE = 3'h1;
	// ==========================================================
	// Modes
	typedef enum logic [1:0] {
		FMR_M_RX_BACK150 = 2'b00,
		FMR_M_TX1200     = 2'b01,
		FMR_M_RX_BACK5   = 2'b10,
		FMR_M_ZERO_POWER = 2'b11
	} fmr_mode_t;
	// ==========================================================
	// Host registers
	localparam logic [7:0] CTRL_OFF   = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] RXDATA_OFF = 8'h08;
	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_EQ_BIT   = 2;
	localparam int CTRL_TXD_BIT  = 3;
	localparam int CTRL_RET_BIT  = 4;
	localparam logic [4:0] CTRL_RESET = 5'h0B;
	localparam int ST_DET_BIT    = 0;
	localparam int ST_RXD_BIT    = 1;
	localparam int ST_READY_FLAG_N_BIT   = 2;
	localparam int ST_SETTLE_BIT = 3;
	localparam int ST_VALID_BIT  = 4;
endpackage

// >>> core/fmr_link_if.sv
// Pin-level link between the modem device and its host controller
`timescale 1ns/1ps
`default_nettype none
interface fmr_link_if;
	logic mode_sel_lo;
	logic mode_sel_hi;
	logic equaliser_select;
	logic txd;
	logic strobe;
	logic rxd;
	logic energy_detect;
	logic ready_flag_n_o;
	logic ready_flag_n_oe;
	logic ready_flag_n;
	logic tone_output;
	logic tone_mid;
	// Open drain with external pull-up
	assign ready_flag_n = ready_flag_n_oe ? ready_flag_n_o : 1'b1;
	modport device (
		input  mode_sel_lo, mode_sel_hi, equaliser_select, txd, strobe,
		output rxd, energy_detect, ready_flag_n_o, ready_flag_n_oe, tone_output, tone_mid
	);
	modport host (
		output mode_sel_lo, mode_sel_hi, equaliser_select, txd, strobe,
		input  rxd, energy_detect, ready_flag_n
	);
endinterface
`default_nettype wire

// >>> core/fmr_sync.sv
// Two-flop synchroniser for a group of levels
`timescale 1ns/1ps
`default_nettype none
module fmr_sync #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] d,
	output var  logic [W-1:0] q
);
	logic [W-1:0] meta_ff;

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			meta_ff <= INIT;
			q       <= INIT;
		end
		else
		begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule
`default_nettype wire

// >>> core/fmr_device.sv
// Modem device end: mode decode, tone select, energy detect and receive retiming
// Overview of operation
// RL1 - All timing divided from one reference clock
// RL2 - Mode pins select rx, tx rates, retime (here pins select rx, tx rates, zero-power; strobe low enables retiming)
// RL3 - Zero-power removes power, stops oscillator
// RL4 - Host waits 20ms after leaving zero-power
// RL5 - Host holds zero-power while clock stopped
// RL6 - Equaliser select low flat, high equalised
// RL7 - Detect after sustained level, with hysteresis
// RL8 - Raw demodulator on rxd when not retiming
// RL9 - Detect and rxd low when receiver off
// RL10 - Mode 01: 2200Hz for 0, 1200Hz for 1
// RL11 - Back channel tones; mode 10 silent zero
// RL12 - Characters: start plus nine bits at 1200
// RL13 - Start edge triggers capture of nine bits
// RL14 - Ninth bit copies register, restarts search
// RL15 - Strobe low at transfer: ready, first bit
// RL16 - Nine strobes; first eight falls shift
// RL17 - First strobe rise releases ready
// RL18 - After ninth pulse rxd returns raw
// RL19 - Host holds strobe low, or high disables
// RL20 - Host reads nine bits within one character
// RL21 - Strobe high: raw data, never ready
// RL22 - Ready is open-drain active-low request
// RL23 - Bit timing divided, samples at bit centre
// RL24 - Receiver off or zero-power resets retiming
`timescale 1ns/1ps
`default_nettype none
module fmr_device #(
	parameter int BIT_CYC   = fmr_pkg::BIT_CYC,
	parameter int HALF_BIT  = fmr_pkg::HALF_BIT,
	parameter int DET_ON    = fmr_pkg::DET_ON_CYC,
	parameter int DET_OFF   = fmr_pkg::DET_OFF_CYC,
	parameter int HALF_2200 = fmr_pkg::HALF_2200,
	parameter int HALF_1200 = fmr_pkg::HALF_1200,
	parameter int HALF_487  = fmr_pkg::HALF_487,
	parameter int HALF_387  = fmr_pkg::HALF_387
) (
	input  wire logic  pclk,
	input  wire logic  presetn,
	fmr_link_if.device link,
	input  wire logic  demod_raw,
	input  wire logic  level_hi,
	input  wire logic  level_lo,
	output var  logic  eq_active,
	output var  logic  osc_enable,
	output var  logic  rx_enabled
);
	localparam int W = fmr_pkg::CNT_W;

	typedef enum logic [1:0] {
		FMR_CAP_IDLE  = 2'b00,
		FMR_CAP_START = 2'b01,
		FMR_CAP_BITS  = 2'b10
	} fmr_cap_t;

	// ==========================================================
	// Input synchronisers
	logic [7:0] sync_q;
	logic       mode_lo_s;
	logic       mode_hi_s;
	logic       eq_s;
	logic       txd_s;
	logic       strobe_s;
	logic       demod_s;
	logic       lvl_hi_s;
	logic       lvl_lo_s;

	fmr_sync #(.W(8), .INIT(fmr_pkg::DEV_IDLE)) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({link.mode_sel_lo, link.mode_sel_hi, link.equaliser_select, link.txd,
		         link.strobe, demod_raw, level_hi, level_lo}),
		.q     (sync_q)
	);
	assign {mode_lo_s, mode_hi_s, eq_s, txd_s, strobe_s, demod_s, lvl_hi_s, lvl_lo_s} = sync_q;

	// ==========================================================
	// Mode decode
	fmr_pkg::fmr_mode_t mode;
	logic               zero_power;
	logic               rx_on;

	assign mode       = fmr_pkg::fmr_mode_t'({mode_hi_s, mode_lo_s}); // RL2
	assign zero_power = (mode == fmr_pkg::FMR_M_ZERO_POWER);
	assign rx_on      = (mode == fmr_pkg::FMR_M_RX_BACK150) || (mode == fmr_pkg::FMR_M_RX_BACK5); // RL2

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			osc_enable <= 1'b0;
			eq_active  <= 1'b0;
			rx_enabled <= 1'b0;
		end
		else
		begin
			osc_enable <= !zero_power; // RL3
			eq_active  <= eq_s && !zero_power; // RL6
			rx_enabled <= rx_on;
		end
	end

	// ==========================================================
	// Edge detection on synchronised levels
	logic strobe_d_ff;
	logic demod_d_ff;
	logic strobe_rise;
	logic strobe_fall;
	logic demod_fall;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			strobe_d_ff <= 1'b1;
			demod_d_ff  <= 1'b1;
		end
		else
		begin
			strobe_d_ff <= strobe_s;
			demod_d_ff  <= demod_s;
		end
	end
	assign strobe_rise = strobe_s && !strobe_d_ff;
	assign strobe_fall = !strobe_s && strobe_d_ff;
	assign demod_fall  = !demod_s && demod_d_ff;

	// ==========================================================
	// Capture register, bit timing from the clock divider
	fmr_cap_t       cap_ff;
	logic [W-1:0]   timer_ff;
	logic [3:0]     bit_cnt_ff;
	logic [8:0]     cap_reg_ff;
	logic [8:0]     nxt_cap_reg;
	logic           cap_done;

	assign nxt_cap_reg = {demod_s, cap_reg_ff[8:1]};
	assign cap_done    = (cap_ff == FMR_CAP_BITS) && (timer_ff == '0) && (bit_cnt_ff == 4'h8); // RL14

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			cap_ff     <= FMR_CAP_IDLE;
			timer_ff   <= '0;
			bit_cnt_ff <= 4'h0;
			cap_reg_ff <= 9'h000;
		end
		else if (!rx_on)
		begin
			cap_ff     <= FMR_CAP_IDLE; // RL24
			timer_ff   <= '0;
			bit_cnt_ff <= 4'h0;
		end
		else
		begin
			case (cap_ff)
				FMR_CAP_IDLE:
				begin
					if (demod_fall) // RL13
					begin
						timer_ff <= W'(HALF_BIT - 1); // RL23
						cap_ff   <= FMR_CAP_START;
					end
				end
				FMR_CAP_START:
				begin
					if (timer_ff != '0)
						timer_ff <= timer_ff - 1'b1;
					else if (!demod_s)
					begin
						timer_ff   <= W'(BIT_CYC - 1); // RL23
						bit_cnt_ff <= 4'h0;
						cap_ff     <= FMR_CAP_BITS;
					end
					else
						cap_ff <= FMR_CAP_IDLE;
				end
				FMR_CAP_BITS:
				begin
					if (timer_ff != '0)
						timer_ff <= timer_ff - 1'b1;
					else
					begin
						cap_reg_ff <= nxt_cap_reg; // RL12 RL13
						timer_ff   <= W'(BIT_CYC - 1);
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
						if (bit_cnt_ff == 4'h8)
							cap_ff <= FMR_CAP_IDLE; // RL14
					end
				end
				default:
					cap_ff <= FMR_CAP_IDLE;
			endcase
		end
	end

	// ==========================================================
	// Output register and ready flag
	logic [8:0] out_reg_ff;
	logic [3:0] fall_cnt_ff;
	logic       out_active_ff;
	logic       ready_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			out_reg_ff    <= 9'h000;
			fall_cnt_ff   <= 4'h0;
			out_active_ff <= 1'b0;
			ready_ff      <= 1'b0;
		end
		else if (!rx_on)
		begin
			out_active_ff <= 1'b0; // RL24
			ready_ff      <= 1'b0;
			fall_cnt_ff   <= 4'h0;
		end
		else if (cap_done)
		begin
			out_reg_ff  <= nxt_cap_reg; // RL14
			fall_cnt_ff <= 4'h0;
			// Strobe high means retiming off: raw data, no ready
			out_active_ff <= !strobe_s; // RL15 RL21
			ready_ff      <= !strobe_s; // RL15 RL21
		end
		else
		begin
			if (strobe_rise)
				ready_ff <= 1'b0; // RL17
			if (out_active_ff && strobe_fall)
			begin
				if (fall_cnt_ff == 4'h8)
					out_active_ff <= 1'b0; // RL18
				else
				begin
					out_reg_ff  <= {1'b0, out_reg_ff[8:1]}; // RL16
					fall_cnt_ff <= fall_cnt_ff + 4'h1;
				end
			end
		end
	end

	// Open drain: only ever pulls low
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			link.ready_flag_n_o  <= 1'b0;
			link.ready_flag_n_oe <= 1'b0;
		end
		else
		begin
			link.ready_flag_n_o  <= 1'b0; // RL22
			link.ready_flag_n_oe <= ready_ff; // RL22
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			link.rxd <= 1'b0;
		else if (!rx_on)
			link.rxd <= 1'b0; // RL9
		else if (out_active_ff)
			link.rxd <= out_reg_ff[0]; // RL15
		else
			link.rxd <= demod_s; // RL8 RL21
	end

	// ==========================================================
	// Energy detect with time hysteresis; amplitude hysteresis via two thresholds
	logic [W-1:0] det_cnt_ff;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			link.energy_detect <= 1'b0;
			det_cnt_ff         <= '0;
		end
		else if (!rx_on)
		begin
			link.energy_detect <= 1'b0; // RL9
			det_cnt_ff         <= '0;
		end
		else if (!link.energy_detect)
		begin
			if (!lvl_hi_s)
				det_cnt_ff <= '0;
			else if (det_cnt_ff == W'(DET_ON - 1))
			begin
				link.energy_detect <= 1'b1; // RL7
				det_cnt_ff         <= '0;
			end
			else
				det_cnt_ff <= det_cnt_ff + 1'b1;
		end
		else
		begin
			if (lvl_lo_s)
				det_cnt_ff <= '0;
			else if (det_cnt_ff == W'(DET_OFF - 1))
			begin
				link.energy_detect <= 1'b0; // RL7
				det_cnt_ff         <= '0;
			end
			else
				det_cnt_ff <= det_cnt_ff + 1'b1;
		end
	end

	// ==========================================================
	// Tone generator: square wave, half period picked by mode and data
	logic [W-1:0] tone_half;
	logic [W-1:0] tone_cnt_ff;

	always_comb
	begin
		case (mode)
			fmr_pkg::FMR_M_RX_BACK150: tone_half = txd_s ? W'(HALF_387) : W'(HALF_487); // RL11
			fmr_pkg::FMR_M_TX1200:     tone_half = txd_s ? W'(HALF_1200) : W'(HALF_2200); // RL10
			fmr_pkg::FMR_M_RX_BACK5:   tone_half = txd_s ? W'(HALF_387) : '0; // RL11
			default:                   tone_half = '0;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tone_cnt_ff      <= '0;
			link.tone_output <= 1'b0;
			link.tone_mid    <= 1'b0;
		end
		else if (tone_half == '0)
		begin
			tone_cnt_ff      <= '0;
			link.tone_output <= 1'b0;
			link.tone_mid    <= !zero_power; // RL11 RL3
		end
		else
		begin
			link.tone_mid <= 1'b0;
			if (tone_cnt_ff >= tone_half - 1'b1)
			begin
				tone_cnt_ff      <= '0;
				link.tone_output <= !link.tone_output;
			end
			else
				tone_cnt_ff <= tone_cnt_ff + 1'b1; // RL1
		end
	end
endmodule
`default_nettype wire

// >>> core/fmr_host.sv
// Host controller end: APB registers, mode pins, strobe generator and bit reader
`timescale 1ns/1ps
`default_nettype none
module fmr_host #(
	parameter int ZP_WAIT = fmr_pkg::ZP_WAIT_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output var  logic [31:0] prdata,
	output var  logic        pready,
	output var  logic        pslverr,
	fmr_link_if.host         link
);
	localparam int W = fmr_pkg::CNT_W;

	typedef enum logic [0:0] {
		FMR_H_IDLE = 1'b0,
		FMR_H_RUN  = 1'b1
	} fmr_hst_t;

	// ==========================================================
	// Synchronisers
	logic [2:0] sync_q;
	logic       det_s;
	logic       rxd_s;
	logic       ready_flag_n_s;

	fmr_sync #(.W(3), .INIT(fmr_pkg::HOST_IDLE)) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({link.energy_detect, link.rxd, link.ready_flag_n}),
		.q     (sync_q)
	);
	assign {det_s, rxd_s, ready_flag_n_s} = sync_q;

	// ==========================================================
	// APB slave, no wait states: pready is high in the first access cycle
	logic [4:0] ctrl_ff;
	logic [8:0] rx_byte_ff;
	logic [8:0] data_ff;
	logic       valid_ff;
	logic       settled_ff;
	logic       done;
	logic       wr_ok;
	logic       rd_data;
	logic       setup;

	assign setup   = psel && !penable && !pready;
	assign wr_ok   = psel && penable && pready && pwrite && (paddr == fmr_pkg::CTRL_OFF);
	assign rd_data = psel && penable && pready && !pwrite && (paddr == fmr_pkg::RXDATA_OFF);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end
		else
		begin
			pready  <= setup;
			pslverr <= setup && (paddr != fmr_pkg::CTRL_OFF) && (paddr != fmr_pkg::STATUS_OFF)
				&& (paddr != fmr_pkg::RXDATA_OFF);
			if (setup)
			begin
				case (paddr)
					fmr_pkg::CTRL_OFF:   prdata <= {27'h0, ctrl_ff};
					fmr_pkg::STATUS_OFF: prdata <= {27'h0, valid_ff, settled_ff, ready_flag_n_s, rxd_s, det_s};
					fmr_pkg::RXDATA_OFF: prdata <= {23'h0, data_ff};
					default:             prdata <= 32'h00000000;
				endcase
			end
		end
	end

	// Reset in zero-power so the device is safe before the clock runs
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ctrl_ff <= fmr_pkg::CTRL_RESET; // RL5
		else if (wr_ok)
			ctrl_ff <= pwdata[4:0];
	end

	// A new byte wins over the clear by read
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			valid_ff <= 1'b0;
			data_ff  <= 9'h000;
		end
		else if (done)
		begin
			valid_ff <= 1'b1;
			data_ff  <= rx_byte_ff;
		end
		else if (rd_data)
			valid_ff <= 1'b0;
	end

	// ==========================================================
	// Settling wait after zero-power
	logic [W-1:0] settle_cnt_ff;
	logic         zp_cmd;

	assign zp_cmd = (ctrl_ff[fmr_pkg::CTRL_MODE_LSB +: 2] == fmr_pkg::FMR_M_ZERO_POWER);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			settle_cnt_ff <= '0;
			settled_ff    <= 1'b0;
		end
		else if (zp_cmd)
		begin
			settle_cnt_ff <= W'(ZP_WAIT - 1); // RL4
			settled_ff    <= 1'b0;
		end
		else if (settle_cnt_ff != '0)
			settle_cnt_ff <= settle_cnt_ff - 1'b1;
		else
			settled_ff <= 1'b1; // RL4
	end

	// ==========================================================
	// Mode and data pins
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			link.mode_sel_lo      <= 1'b1; // RL5
			link.mode_sel_hi      <= 1'b1; // RL5
			link.equaliser_select <= 1'b0;
			link.txd              <= 1'b1;
		end
		else
		begin
			link.mode_sel_lo      <= ctrl_ff[fmr_pkg::CTRL_MODE_LSB];
			link.mode_sel_hi      <= ctrl_ff[fmr_pkg::CTRL_MODE_LSB + 1];
			link.equaliser_select <= ctrl_ff[fmr_pkg::CTRL_EQ_BIT];
			// Mark level until the device has settled
			link.txd <= settled_ff ? ctrl_ff[fmr_pkg::CTRL_TXD_BIT] : 1'b1; // RL4
		end
	end

	// ==========================================================
	// Strobe generator: divider ticks, nine pulses, one bit read per rise
	fmr_hst_t     hst_ff;
	logic [W-1:0] div_ff;
	logic [4:0]   phase_ff;
	logic         retime;
	logic         tick;

	assign retime = ctrl_ff[fmr_pkg::CTRL_RET_BIT] && settled_ff;
	assign tick   = (div_ff == W'(fmr_pkg::STB_HALF - 1));
	assign done   = (hst_ff == FMR_H_RUN) && tick && (phase_ff == 5'(fmr_pkg::NPHASE - 1));

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hst_ff      <= FMR_H_IDLE;
			div_ff      <= '0;
			phase_ff    <= 5'h00;
			rx_byte_ff  <= 9'h000;
			link.strobe <= 1'b1; // RL19
		end
		else
		begin
			case (hst_ff)
				FMR_H_IDLE:
				begin
					link.strobe <= !retime; // RL19
					div_ff      <= '0;
					phase_ff    <= 5'h00;
					if (retime && !ready_flag_n_s)
						hst_ff <= FMR_H_RUN;
				end
				FMR_H_RUN:
				begin
					// Whole burst is far shorter than one character time
					div_ff <= tick ? '0 : div_ff + 1'b1; // RL20
					if (tick)
					begin
						phase_ff <= phase_ff + 5'h01;
						if (!phase_ff[0])
						begin
							rx_byte_ff  <= {rxd_s, rx_byte_ff[8:1]};
							link.strobe <= 1'b1; // RL16
						end
						else
							link.strobe <= 1'b0; // RL16
						if (done)
							hst_ff <= FMR_H_IDLE;
					end
				end
				default:
					hst_ff <= FMR_H_IDLE;
			endcase
		end
	end
endmodule
`default_nettype wire

// >>> tb/fmr_link_assertions.sv
// Concurrent checks on the pin-level link between modem device and host
`timescale 1ns/1ps
`default_nettype none
module fmr_link_assertions #(
	parameter int HALF_2200 = fmr_pkg::HALF_2200,
	parameter int HALF_1200 = fmr_pkg::HALF_1200,
	parameter int HALF_487  = fmr_pkg::HALF_487,
	parameter int HALF_387  = fmr_pkg::HALF_387
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic mode_sel_lo,
	input wire logic mode_sel_hi,
	input wire logic txd,
	input wire logic strobe,
	input wire logic rxd,
	input wire logic energy_detect,
	input wire logic ready_flag_n,
	input wire logic tone_output,
	input wire logic tone_mid
);
	// ==========================================================
	// Helper logic
	// Tone spacing is only judged once pins have been calm for two slowest half periods
	localparam int SETTLE = 2 * HALF_387 + 8;
	logic [1:0] mode;
	int         gap_ff;
	int         calm_ff;
	int         exp_half;
	assign mode = {mode_sel_hi, mode_sel_lo};
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			gap_ff <= 0;
		else if ($changed(tone_output))
			gap_ff <= 1;
		else
			gap_ff <= gap_ff + 1;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			calm_ff <= 0;
		else if ($changed(mode) || $changed(txd))
			calm_ff <= 0;
		else if (calm_ff <= SETTLE)
			calm_ff <= calm_ff + 1;
	end
	always_comb
	begin
		case (mode)
			2'b00:   exp_half = txd ? HALF_387 : HALF_487;
			2'b01:   exp_half = txd ? HALF_1200 : HALF_2200;
			default: exp_half = HALF_387;
		endcase
	end
	// ==========================================================
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_off_rx_low: assert property ((mode == 2'b01 || mode == 2'b11) [*8] |-> !rxd && !energy_detect)
		else $error("rxd or detect high with receiver off");
	a_off_no_ready: assert property ((mode == 2'b01 || mode == 2'b11) [*8] |-> ready_flag_n)
		else $error("ready asserted with receiver off");
	a_strobe_high_quiet: assert property (strobe [*8] |-> ready_flag_n)
		else $error("ready low while strobe held high");
	a_ready_release: assert property ($rose(strobe) && !ready_flag_n |-> ##[1:5] ready_flag_n)
		else $error("ready not released after strobe rise");
	a_zp_silent: assert property ((mode == 2'b11) [*8] |-> !tone_output && !tone_mid)
		else $error("tone active in zero power");
	a_mode10_rest: assert property ((mode == 2'b10 && !txd) [*8] |-> tone_mid)
		else $error("tone not resting at mid supply");
	a_tone_half: assert property ($changed(tone_output) && calm_ff > SETTLE && mode != 2'b11
		&& !(mode == 2'b10 && !txd) |-> gap_ff == exp_half)
		else $error("tone half period wrong");
	a_ready_strobe_low: assert property ($fell(ready_flag_n) |-> !$past(strobe, 4))
		else $error("ready asserted with strobe high");
	c_ready: cover property ($fell(ready_flag_n));
	c_release: cover property ($rose(strobe) && !ready_flag_n);
	c_tone_hi: cover property (mode == 2'b01 && !txd && $changed(tone_output));
	c_detect: cover property ($rose(energy_detect));
endmodule
`default_nettype wire

// >>> tb/fsk_modem_mode_rx_retime_tb.sv
// Testbench joining modem device and host end over the pin-level link
`timescale 1ns/1ps
`default_nettype none
module fsk_modem_mode_rx_retime_tb;
	// ==========================================================
	// Shortened counts keep the run brief
	localparam int BITC = 40;
	localparam int DON  = 16;
	localparam int DOFF = 8;
	localparam int H22  = 5;
	localparam int H12  = 9;
	localparam int H48  = 12;
	localparam int H38  = 15;
	localparam int ZPW  = 50;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        demod_raw;
	logic        level_hi;
	logic        level_lo;
	logic        eq_active;
	logic        osc_enable;
	logic        rx_enabled;
	logic [31:0] rd_q;
	logic        rd_e;
	int          err_total;
	int          comparisons;
	int          rdy_lows;
	int          rdy_mark;
	logic [4:0]  tone_ctl [6] = '{5'h00, 5'h08, 5'h01, 5'h09, 5'h02, 5'h0A};
	int          tone_half [6] = '{12, 15, 5, 9, 0, 15};
	fmr_link_if link_bus ();
	fmr_device #(.BIT_CYC(BITC), .HALF_BIT(BITC / 2), .DET_ON(DON), .DET_OFF(DOFF), .HALF_2200(H22),
		.HALF_1200(H12), .HALF_487(H48), .HALF_387(H38)) i_fmr_device (.pclk(pclk), .presetn(presetn),
		.link(link_bus), .demod_raw(demod_raw), .level_hi(level_hi), .level_lo(level_lo),
		.eq_active(eq_active), .osc_enable(osc_enable), .rx_enabled(rx_enabled));
	fmr_host #(.ZP_WAIT(ZPW)) i_fmr_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link(link_bus));
	fmr_link_assertions #(.HALF_2200(H22), .HALF_1200(H12), .HALF_487(H48), .HALF_387(H38)) i_fmr_link_assertions (
		.pclk(pclk), .presetn(presetn), .mode_sel_lo(link_bus.mode_sel_lo), .mode_sel_hi(link_bus.mode_sel_hi),
		.txd(link_bus.txd), .strobe(link_bus.strobe), .rxd(link_bus.rxd), .energy_detect(link_bus.energy_detect),
		.ready_flag_n(link_bus.ready_flag_n), .tone_output(link_bus.tone_output), .tone_mid(link_bus.tone_mid));
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end
	always @(posedge pclk)
		if (link_bus.ready_flag_n === 1'b0)
			rdy_lows++;
	// ==========================================================
	// Tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: saw %0h, expected %0h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up;
		$display("comparisons %0d, mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd_q = prdata;
		rd_e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			err_total++;
			wrap_up();
		end
	endtask
	task automatic poll_st(input int b);
		int n;
		n = 0;
		do
		begin
			apb(1'b0, fmr_pkg::STATUS_OFF, 32'h0);
			n++;
		end
		while (rd_q[b] !== 1'b1 && n < 400);
		if (rd_q[b] !== 1'b1)
		begin
			err_total++;
			wrap_up();
		end
	endtask
	task automatic send_char(input logic [8:0] b);
		demod_raw <= 1'b0;
		repeat (BITC) @(posedge pclk);
		for (int i = 0; i < 9; i++)
		begin
			demod_raw <= b[i];
			repeat (BITC) @(posedge pclk);
		end
		demod_raw <= 1'b1;
		repeat (BITC) @(posedge pclk);
	endtask
	task automatic getbyte(input logic [8:0] exp);
		int n;
		n = 0;
		while (link_bus.ready_flag_n !== 1'b0 && n < 2000)
		begin
			@(posedge pclk);
			n++;
		end
		chk(link_bus.ready_flag_n, 1'b0);
		if (n >= 2000)
			wrap_up();
		repeat (2) @(posedge pclk);
		chk(link_bus.rxd, exp[0]);
		poll_st(fmr_pkg::ST_VALID_BIT);
		apb(1'b0, fmr_pkg::RXDATA_OFF, 32'h0);
		chk(rd_q, {23'h0, exp});
	endtask
	task automatic meas(input int exp);
		logic t;
		int   n;
		for (int k = 0; k < 2; k++)
		begin
			t = link_bus.tone_output;
			n = 0;
			while (link_bus.tone_output === t && n < 100)
			begin
				@(posedge pclk);
				n++;
			end
		end
		chk(n, exp);
		if (n >= 100)
			wrap_up();
	endtask
	// ==========================================================
	// Main sequence
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{demod_raw, level_hi, level_lo} = 3'b100;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, fmr_pkg::CTRL_OFF, 32'h0);
		chk(rd_q, 32'h0000000B);
		chk({link_bus.mode_sel_hi, link_bus.mode_sel_lo, link_bus.rxd, link_bus.energy_detect, osc_enable}, 5'h18);
		apb(1'b0, 8'h0C, 32'h0);
		chk({rd_e, rd_q[30:0]}, 32'h80000000);
		apb(1'b1, fmr_pkg::CTRL_OFF, 32'h14);
		apb(1'b0, fmr_pkg::STATUS_OFF, 32'h0);
		chk(rd_q[fmr_pkg::ST_SETTLE_BIT], 1'b0);
		poll_st(fmr_pkg::ST_SETTLE_BIT);
		chk({eq_active, osc_enable, rx_enabled}, 3'h7);
		// Detect needs the upper level to rise, the lower level to fall
		level_hi <= 1'b1;
		level_lo <= 1'b1;
		repeat (DON - 4) @(posedge pclk);
		chk(link_bus.energy_detect, 1'b0);
		repeat (12) @(posedge pclk);
		chk(link_bus.energy_detect, 1'b1);
		level_hi <= 1'b0;
		repeat (DON + 8) @(posedge pclk);
		chk(link_bus.energy_detect, 1'b1);
		level_lo <= 1'b0;
		repeat (DOFF - 4) @(posedge pclk);
		chk(link_bus.energy_detect, 1'b1);
		repeat (12) @(posedge pclk);
		chk(link_bus.energy_detect, 1'b0);
		fork
			begin
				send_char(9'h1C3);
				send_char(9'h03C);
			end
			begin
				getbyte(9'h1C3);
				getbyte(9'h03C);
			end
		join
		repeat (4) @(posedge pclk);
		chk(link_bus.rxd, 1'b1);
		level_hi <= 1'b1;
		level_lo <= 1'b1;
		repeat (DON + 8) @(posedge pclk);
		rdy_mark = rdy_lows;
		fork
			send_char(9'h1F0);
			begin
				repeat (100) @(posedge pclk);
				apb(1'b1, fmr_pkg::CTRL_OFF, 32'h11);
				repeat (8) @(posedge pclk);
				chk({link_bus.rxd, link_bus.energy_detect, link_bus.ready_flag_n, rx_enabled}, 4'h2);
				apb(1'b1, fmr_pkg::CTRL_OFF, 32'h14);
			end
		join
		repeat (100) @(posedge pclk);
		chk(rdy_lows - rdy_mark, 0);
		apb(1'b0, fmr_pkg::STATUS_OFF, 32'h0);
		chk(rd_q[fmr_pkg::ST_VALID_BIT], 1'b0);
		apb(1'b1, fmr_pkg::CTRL_OFF, 32'h00);
		repeat (8) @(posedge pclk);
		rdy_mark = rdy_lows;
		demod_raw <= 1'b0;
		repeat (6) @(posedge pclk);
		chk(link_bus.rxd, 1'b0);
		demod_raw <= 1'b1;
		repeat (6) @(posedge pclk);
		chk(link_bus.rxd, 1'b1);
		send_char(9'h0A5);
		chk(rdy_lows - rdy_mark, 0);
		for (int k = 0; k < 6; k++)
		begin
			apb(1'b1, fmr_pkg::CTRL_OFF, {27'h0, tone_ctl[k]});
			repeat (10) @(posedge pclk);
			if (tone_half[k] != 0)
				meas(tone_half[k]);
			chk(link_bus.tone_mid, tone_half[k] == 0);
		end
		apb(1'b1, fmr_pkg::CTRL_OFF, 32'h0B);
		repeat (8) @(posedge pclk);
		chk({osc_enable, rx_enabled, link_bus.rxd, link_bus.energy_detect, link_bus.tone_mid, link_bus.ready_flag_n},
			6'h01);
		wrap_up();
	end
endmodule
`default_nettype wire
